/* File: shared/acs_pkg.sv */
// Package: constants, register map and carriers of the accumulator datapath
package acs_pkg;
    // ****************************************
    // Widths and register map
    // ****************************************
    localparam int ACC_W = 40;
    localparam logic [7:0] CORE_CONTROL_OFS = 8'h00;
    localparam logic [7:0] TRAP_CONTROL_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] WB_POINTER_OFS = 8'h0C;
    localparam logic [7:0] ACC_A_LOW_OFS = 8'h10;
    localparam logic [7:0] ACC_A_HIGH_OFS = 8'h14;
    localparam logic [7:0] ACC_B_LOW_OFS = 8'h18;
    localparam logic [7:0] ACC_B_HIGH_OFS = 8'h1C;
    // Core control field positions
    localparam int ROUND_STYLE_BIT = 1;
    localparam int CLIP_WIDTH_BIT = 4;
    localparam int STORE_CLIP_BIT = 5;
    localparam int CLIP_EN_B_BIT = 6;
    localparam int CLIP_EN_A_BIT = 7;
    // Trap control field positions
    localparam int GUARD_TRAP_A_BIT = 0;
    localparam int GUARD_TRAP_B_BIT = 1;
    localparam int WRAP_TRAP_BIT = 2;
    // Status field positions
    localparam int GUARD_A_BIT = 0;
    localparam int GUARD_B_BIT = 1;
    localparam int CLIP_A_BIT = 2;
    localparam int CLIP_B_BIT = 3;
    localparam int EITHER_GUARD_BIT = 4;
    localparam int EITHER_CLIP_BIT = 5;
    // Reset values
    localparam logic [7:0] CORE_CONTROL_RST = 8'h00;
    localparam logic [2:0] TRAP_CONTROL_RST = 3'h0;
    localparam logic [15:0] WB_POINTER_RST = 16'h0000;
    localparam logic [ACC_W-1:0] ACC_RST = 40'h00_0000_0000;
    // Saturation and store limits
    localparam logic [ACC_W-1:0] SAT40_POS = 40'h7F_FFFF_FFFF;
    localparam logic [ACC_W-1:0] SAT40_NEG = 40'h80_0000_0000;
    localparam logic [ACC_W-1:0] SAT32_POS = 40'h00_7FFF_FFFF;
    localparam logic [ACC_W-1:0] SAT32_NEG = 40'h00_8000_0000;
    localparam logic [23:0] STORE_POS_LIM = 24'h007FFF;
    localparam logic [23:0] STORE_NEG_LIM = 24'hFF8000;
    localparam logic [15:0] STORE_POS_MAX = 16'h7FFF;
    localparam logic [15:0] STORE_NEG_MAX = 16'h8000;
    localparam logic [15:0] WB_STEP = 16'h0002;
    // ****************************************
    // Operation carriers
    // ****************************************
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_ACCUM = 2'h1,
        OP_ACCUM_NO_WB = 2'h2,
        OP_STORE = 2'h3
    } acs_kind_t;
    typedef enum logic [1:0] {
        WB_NONE = 2'h0,
        WB_DIRECT = 2'h1,
        WB_INDIRECT = 2'h2
    } acs_wb_t;
    typedef struct packed {
        acs_kind_t kind;
        logic acc_sel;
        logic subtract;
        logic zero_acc;
        logic carry_in;
        logic [ACC_W-1:0] operand;
        acs_wb_t wb_mode;
        logic round_req;
        logic [15:0] store_addr;
    } acs_op_t;
    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [15:0] data;
    } acs_store_t;
endpackage : acs_pkg

/* File: logic/acs_datapath.sv */
// Accumulator adder, saturation, rounding and store logic with APB registers
//
// Function
// - 40-bit sign-extended adder; one accumulator is source and destination.
// - Accumulator input may be zero; subtract complements operand, borrow low.
// - Guard flag set when result bits 39..32 differ.
// - Guard flags refreshed by every adder operation on their accumulator.
// - Guard flag with its trap enable requests warning trap.
// - Clip flags sticky: hardware sets, only software clears.
// - Clip means bit 31 or bit 39 overflow; bit 39 when unsaturated.
// - Unsaturated clip flag with wrap trap enable requests warning trap.
// - Status shows OR of guard flags and OR of clip flags.
// - Clip enables at control bits 7:6, width select at bit 4.
// - 40-bit mode loads full-scale 40-bit limits and sets clip flag.
// - 32-bit mode loads 32-bit limits and sets clip flag.
// - In 32-bit saturation guard flags never set.
// - Unsaturated accumulator wraps; bit 39 overflow still sets clip.
// - Accumulating ops may store rounded non-target high word.
// - Direct write-back puts rounded word into pointer register.
// - Indirect write-back stores at pointer, then pointer plus 2.
// - Style select picks rounding; unrounded stores truncate high word.
// - Conventional rounding adds bit 15 into high word.
// - Convergent: low word exactly 0x8000 rounds up only if bit 16.
// - Plain store truncates, rounded store rounds, write-back always rounds.
// - Store clip limits to 0x7FFF/0x8000 by bit 39; accumulator untouched.
`timescale 1ns/100ps
`default_nettype none
module acs_datapath
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Operation from the instruction sequencer
    input wire acs_pkg::acs_op_t op_i,
    // Data-space store toward the X bus
    output acs_pkg::acs_store_t store_o,
    // Arithmetic warning trap request
    output logic trap_request_o
);
    import acs_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] core_control_reg;
    logic [2:0] trap_control_reg;
    logic [15:0] writeback_pointer_reg;
    logic [15:0] writeback_pointer_next;
    logic [ACC_W-1:0] acc_reg [2];
    logic [1:0] guard_flag_reg;
    logic [1:0] clip_flag_reg;
    logic [1:0] clip_flag_next;
    acs_store_t store_reg;
    acs_store_t store_next;

    // Control field decode
    wire logic round_style_select = core_control_reg[ROUND_STYLE_BIT];
    wire logic clip_width_select = core_control_reg[CLIP_WIDTH_BIT];
    wire logic store_clip_enable = core_control_reg[STORE_CLIP_BIT];
    wire logic [1:0] clip_enable =
        {core_control_reg[CLIP_EN_B_BIT], core_control_reg[CLIP_EN_A_BIT]};
    wire logic [1:0] guard_trap_en =
        {trap_control_reg[GUARD_TRAP_B_BIT], trap_control_reg[GUARD_TRAP_A_BIT]};
    wire logic wrap_trap_enable = trap_control_reg[WRAP_TRAP_BIT];

    // ****************************************
    // Round and store clip
    // ****************************************
    // Rounding works on the 24-bit upper part so the store clip sees
    // the carry out of the high word rather than a wrapped value.
    function automatic logic [15:0] round_clip(
        input logic [ACC_W-1:0] acc,
        input logic do_round,
        input logic conventional,
        input logic clip_en
    );
        logic inc;
        logic [23:0] upper;
        inc = 1'b0;
        if (do_round)
        begin
            if (conventional)
                inc = acc[15];
            else
                inc = acc[15] & ((|acc[14:0]) | acc[16]);
        end
        upper = acc[39:16] + {23'h0, inc};
        round_clip = upper[15:0];
        if (clip_en && !acc[39] && (upper > STORE_POS_LIM))
            round_clip = STORE_POS_MAX;
        else if (clip_en && acc[39] && (upper < STORE_NEG_LIM))
            round_clip = STORE_NEG_MAX;
    endfunction : round_clip

    // ****************************************
    // Adder and saturation
    // ****************************************
    wire logic op_adder = (op_i.kind == OP_ACCUM) || (op_i.kind == OP_ACCUM_NO_WB);
    wire logic tgt = op_i.acc_sel;
    wire logic [ACC_W-1:0] add_a = op_i.zero_acc ? ACC_RST : acc_reg[tgt];
    wire logic [ACC_W-1:0] add_b = op_i.subtract ? ~op_i.operand : op_i.operand;
    // Carry-in doubles as the active-low borrow when subtracting
    wire logic [ACC_W-1:0] sum = add_a + add_b + {39'h0, op_i.carry_in};

    // Overflow detection on the raw sum
    wire logic ovf39 = (add_a[39] == add_b[39]) && (sum[39] != add_a[39]);
    wire logic true_neg = ovf39 ? ~sum[39] : sum[39];
    wire logic ovf31 = ovf39 || !((&sum[39:31]) || !(|sum[39:31]));
    wire logic sat_on = clip_enable[tgt];
    wire logic sat32 = sat_on && !clip_width_select;
    wire logic clip_hit = sat32 ? ovf31 : ovf39;

    // Saturated or wrapped result
    logic [ACC_W-1:0] acc_result;
    always_comb
    begin
        acc_result = sum;
        if (sat_on && clip_hit)
        begin
            if (sat32)
                acc_result = true_neg ? SAT32_NEG : SAT32_POS;
            else
                acc_result = true_neg ? SAT40_NEG : SAT40_POS;
        end
    end

    // Guard bits never count while 32-bit saturation holds
    wire logic guard_hit =
        !sat32 && !((&acc_result[39:32]) || !(|acc_result[39:32]));

    // ****************************************
    // Write-back and store
    // ****************************************
    wire logic wb_allowed = (op_i.kind == OP_ACCUM) && (op_i.wb_mode != WB_NONE);
    wire logic [15:0] wb_word =
        round_clip(acc_reg[~tgt], 1'b1, round_style_select, store_clip_enable);
    wire logic [15:0] st_word =
        round_clip(acc_reg[tgt], op_i.round_req, round_style_select,
                   store_clip_enable);
    wire logic wb_direct = wb_allowed && (op_i.wb_mode == WB_DIRECT);
    wire logic wb_indirect = wb_allowed && (op_i.wb_mode == WB_INDIRECT);

    // Next store beat and pointer
    always_comb
    begin
        store_next = '0;
        if (op_i.kind == OP_STORE)
        begin
            store_next.valid = 1'b1;
            store_next.addr = op_i.store_addr;
            store_next.data = st_word;
        end
        else if (wb_indirect)
        begin
            store_next.valid = 1'b1;
            store_next.addr = writeback_pointer_reg;
            store_next.data = wb_word;
        end
    end

    // ****************************************
    // APB decode
    // ****************************************
    // Zero wait states: every access completes in its access cycle
    wire logic apb_acc = psel_i && penable_i;
    wire logic apb_wr = apb_acc && pwrite_i;
    wire logic hit_ctl = (paddr_i == CORE_CONTROL_OFS);
    wire logic hit_trap = (paddr_i == TRAP_CONTROL_OFS);
    wire logic hit_stat = (paddr_i == STATUS_OFS);
    wire logic hit_ptr = (paddr_i == WB_POINTER_OFS);
    wire logic hit_acc = (paddr_i == ACC_A_LOW_OFS) || (paddr_i == ACC_A_HIGH_OFS) ||
        (paddr_i == ACC_B_LOW_OFS) || (paddr_i == ACC_B_HIGH_OFS);
    wire logic mapped = hit_ctl || hit_trap || hit_stat || hit_ptr || hit_acc;
    wire logic [1:0] clip_clear =
        {pwdata_i[CLIP_B_BIT], pwdata_i[CLIP_A_BIT]} & {2{apb_wr && hit_stat}};

    // Status word with the combined flags
    wire logic [5:0] status_word = {|clip_flag_reg, |guard_flag_reg,
        clip_flag_reg, guard_flag_reg};

    // Read multiplexer
    logic [31:0] rd_data;
    always_comb
    begin
        rd_data = 32'h0000_0000;
        unique case (paddr_i)
            CORE_CONTROL_OFS: rd_data = {24'h000000, core_control_reg};
            TRAP_CONTROL_OFS: rd_data = {29'h0, trap_control_reg};
            STATUS_OFS: rd_data = {26'h0, status_word};
            WB_POINTER_OFS: rd_data = {16'h0000, writeback_pointer_reg};
            ACC_A_LOW_OFS: rd_data = acc_reg[0][31:0];
            ACC_A_HIGH_OFS: rd_data = {24'h000000, acc_reg[0][39:32]};
            ACC_B_LOW_OFS: rd_data = acc_reg[1][31:0];
            ACC_B_HIGH_OFS: rd_data = {24'h000000, acc_reg[1][39:32]};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    assign prdata_o = rd_data;
    assign pready_o = 1'b1;
    assign pslverr_o = apb_acc && !mapped;

    // ****************************************
    // Flag and pointer next values
    // ****************************************
    // A set in the clearing cycle wins, so no overflow is ever lost
    always_comb
    begin
        clip_flag_next = clip_flag_reg & ~clip_clear;
        if (op_adder && clip_hit)
            clip_flag_next[tgt] = 1'b1;
    end

    // Hardware pointer update beats a software write in the same cycle
    always_comb
    begin
        writeback_pointer_next = writeback_pointer_reg;
        if (apb_wr && hit_ptr)
            writeback_pointer_next = pwdata_i[15:0];
        if (wb_direct)
            writeback_pointer_next = wb_word;
        else if (wb_indirect)
            writeback_pointer_next = writeback_pointer_reg + WB_STEP;
    end

    // ****************************************
    // Clocked state
    // ****************************************
    // Control registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            core_control_reg <= CORE_CONTROL_RST;
            trap_control_reg <= TRAP_CONTROL_RST;
        end
        else
        begin
            if (apb_wr && hit_ctl)
                core_control_reg <= pwdata_i[7:0];
            if (apb_wr && hit_trap)
                trap_control_reg <= pwdata_i[2:0];
        end
    end

    // Accumulators and flags, all settled in the issuing cycle
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            acc_reg[0] <= ACC_RST;
            acc_reg[1] <= ACC_RST;
            guard_flag_reg <= 2'b00;
            clip_flag_reg <= 2'b00;
        end
        else
        begin
            if (op_adder)
            begin
                acc_reg[tgt] <= acc_result;
                guard_flag_reg[tgt] <= guard_hit;
            end
            clip_flag_reg <= clip_flag_next;
        end
    end

    // Pointer and store port
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            writeback_pointer_reg <= WB_POINTER_RST;
            store_reg <= '0;
        end
        else
        begin
            writeback_pointer_reg <= writeback_pointer_next;
            store_reg <= store_next;
        end
    end

    assign store_o = store_reg;

    // Trap request is a level held while any cause stands
    assign trap_request_o = (|(guard_flag_reg & guard_trap_en)) ||
        (wrap_trap_enable && (|(clip_flag_reg & ~clip_enable)));
endmodule : acs_datapath
`default_nettype wire

/* File: sim/acs_dp_assertions.sv */
// Checker: port-level properties of the accumulator datapath
`timescale 1ns/100ps
`default_nettype none
module acs_dp_checker
    import acs_pkg::*;
(
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire acs_pkg::acs_op_t op_i,
    input wire acs_pkg::acs_store_t store_o,
    input wire logic trap_request_o
);
    // ****************************************
    // Shadow of the control registers
    // ****************************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [7:0] cc_reg;
    logic [2:0] tc_reg;
    // Access decode; status reads expose the registered flags
    wire wr_hit = psel_i & penable_i & pwrite_i;
    wire st_rd = psel_i & penable_i & ~pwrite_i & (paddr_i == STATUS_OFS);
    // Shadows follow the same access edge as the device registers
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cc_reg <= CORE_CONTROL_RST;
            tc_reg <= TRAP_CONTROL_RST;
        end
        else if (wr_hit)
        begin
            if (paddr_i == CORE_CONTROL_OFS)
                cc_reg <= pwdata_i[7:0];
            if (paddr_i == TRAP_CONTROL_OFS)
                tc_reg <= pwdata_i[2:0];
        end
    end
    // Steps of a pointer-indirect write-back
    sequence s_wb_ind;
        op_i.kind == OP_ACCUM && op_i.wb_mode == WB_INDIRECT;
    endsequence
    property p_store_taken;
        op_i.kind == OP_STORE |=> store_o.valid && store_o.addr == $past(op_i.store_addr);
    endproperty
    a_store_taken: assert property (p_store_taken) else $error("store not issued");
    property p_no_wb;
        op_i.kind == OP_ACCUM_NO_WB |=> !store_o.valid;
    endproperty
    a_no_wb: assert property (p_no_wb) else $error("write-back on excluded op");
    property p_wb_ind;
        s_wb_ind |=> store_o.valid;
    endproperty
    a_wb_ind: assert property (p_wb_ind) else $error("indirect write-back missing");
    property p_wb_step;
        s_wb_ind ##1 s_wb_ind |=> store_o.addr == $past(store_o.addr) + WB_STEP;
    endproperty
    a_wb_step: assert property (p_wb_step) else $error("pointer step wrong");
    property p_either_guard;
        st_rd |-> prdata_o[EITHER_GUARD_BIT] == (prdata_o[GUARD_A_BIT] | prdata_o[GUARD_B_BIT]);
    endproperty
    a_either_guard: assert property (p_either_guard) else $error("either guard wrong");
    property p_either_clip;
        st_rd |-> prdata_o[EITHER_CLIP_BIT] == (prdata_o[CLIP_A_BIT] | prdata_o[CLIP_B_BIT]);
    endproperty
    a_either_clip: assert property (p_either_clip) else $error("either clip wrong");
    property p_guard_trap;
        st_rd && (prdata_o[GUARD_A_BIT] && tc_reg[GUARD_TRAP_A_BIT]
            || prdata_o[GUARD_B_BIT] && tc_reg[GUARD_TRAP_B_BIT]) |-> trap_request_o;
    endproperty
    a_guard_trap: assert property (p_guard_trap) else $error("guard trap missing");
    property p_wrap_trap;
        st_rd && tc_reg[WRAP_TRAP_BIT] && prdata_o[CLIP_A_BIT] && !cc_reg[CLIP_EN_A_BIT]
            |-> trap_request_o;
    endproperty
    a_wrap_trap: assert property (p_wrap_trap) else $error("wrap trap missing");
    property p_no_trap;
        st_rd && tc_reg == 3'h0 |-> !trap_request_o;
    endproperty
    a_no_trap: assert property (p_no_trap) else $error("trap while disabled");
endmodule : acs_dp_checker
bind acs_datapath acs_dp_checker u_chk
(
    .clock_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .op_i, .store_o, .trap_request_o
);
`default_nettype wire

/* File: sim/acs_seq_model.sv */
// Sequencer model: presents one operation per request, idle otherwise unless hold keeps it until the next request
`timescale 1ns/100ps
`default_nettype none
module acs_seq_model
    import acs_pkg::*;
(
    input wire logic clock_i,
    output acs_pkg::acs_op_t op_o
);
    // Idle word so a finished op is never taken twice
    initial op_o = '0;
    task automatic issue(input acs_op_t o, input logic hold);
        @(posedge clock_i);
        op_o <= o;
        if (!hold)
        begin
            @(posedge clock_i);
            op_o <= '0;
        end
    endtask : issue
endmodule : acs_seq_model
`default_nettype wire

/* File: sim/tb.sv */
// Testbench: adder, saturation, rounding and write-back scenarios
`timescale 1ns/100ps
`default_nettype none
module tb;
    import acs_pkg::*;
    // ****************************************
    // Stimulus tables and signals
    // ****************************************
    typedef struct packed {logic [7:0] cc; logic s; logic [39:0] v; logic [2:0] f;
        logic [39:0] w; logic [39:0] r; logic [7:0] st;} acs_row_t;
    typedef struct packed {logic [7:0] cc; logic [39:0] v; logic r; logic [15:0] d;} acs_rnd_t;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic trap_request_o;
    acs_op_t op_i;
    acs_store_t store_o;
    int miscompares = 0;
    int total_checks = 0;
    logic [31:0] exp_q[$];
    acs_row_t row;
    acs_rnd_t rnd;
    acs_row_t rows[10] = '{
        '{8'h00, 1'b0, 40'h5, 3'b001, 40'h1, 40'h7, 8'h00},
        '{8'h00, 1'b0, 40'h6, 3'b100, 40'h2, 40'h3, 8'h00},
        '{8'h00, 1'b0, 40'h0, 3'b000, 40'h100000000, 40'h100000000, 8'h11},
        '{8'h00, 1'b0, 40'h100000000, 3'b101, 40'h100000000, 40'h0, 8'h00},
        '{8'h00, 1'b0, 40'h7FFFFFFFFF, 3'b000, 40'h1, 40'h8000000000, 8'h35},
        '{8'h90, 1'b0, 40'h7FFFFFFFFF, 3'b000, 40'h1, 40'h7FFFFFFFFF, 8'h35},
        '{8'h90, 1'b0, 40'h8000000000, 3'b101, 40'h1, 40'h8000000000, 8'h35},
        '{8'h80, 1'b0, 40'h007FFFFFFF, 3'b000, 40'h1, 40'h007FFFFFFF, 8'h24},
        '{8'h80, 1'b0, 40'hFF80000000, 3'b101, 40'h1, 40'h0080000000, 8'h24},
        '{8'h50, 1'b1, 40'h7FFFFFFFFF, 3'b000, 40'h1, 40'h7FFFFFFFFF, 8'h3A}};
    acs_rnd_t rnds[9] = '{
        '{8'h02, 40'h0012348000, 1'b0, 16'h1234},
        '{8'h02, 40'h0012348000, 1'b1, 16'h1235},
        '{8'h00, 40'h0012348000, 1'b1, 16'h1234},
        '{8'h00, 40'h0012358000, 1'b1, 16'h1236},
        '{8'h00, 40'h0012350000, 1'b1, 16'h1235},
        '{8'h22, 40'h007FFF8000, 1'b1, 16'h7FFF},
        '{8'h20, 40'hFF00000000, 1'b0, 16'h8000},
        '{8'h00, 40'hFF00000000, 1'b0, 16'h0000},
        '{8'h02, 40'h0090000000, 1'b0, 16'h9000}};
    initial forever #50 clock_i = ~clock_i;
    acs_seq_model seq (.clock_i(clock_i), .op_o(op_i));
    acs_datapath uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .op_i(op_i),
        .store_o(store_o), .trap_request_o(trap_request_o));
    task automatic chk(input string n, input logic [39:0] seen, input logic [39:0] e);
        total_checks++;
        if (seen !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, seen);
            miscompares++;
        end
    endtask : chk
    task automatic tally_and_finish();
        if (miscompares == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    // APB master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic er);
        int n;
        @(posedge clock_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 20);
        if (n >= 20)
            tally_and_finish();
        chk("pslverr", pslverr_o, er);
        if (!w)
            chk("prdata", prdata_o, e);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic op(input acs_kind_t k, input logic s, input logic [2:0] f,
        input logic [39:0] v, input acs_wb_t wb, input logic r, input logic [15:0] d,
        input logic hold);
        acs_op_t o;
        o = '{k, s, f[2], f[1], f[0], v, wb, r, 16'($urandom)};
        if (k == OP_STORE)
            exp_q.push_back({o.store_addr, d});
        seq.issue(o, hold);
    endtask : op
    // Store watcher: each data-space store takes the oldest expectation
    always @(posedge clock_i)
    begin
        if (store_o.valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("extra_store", 1'b1, 1'b0);
            else
                chk("store", {store_o.addr, store_o.data}, exp_q.pop_front());
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        void'($urandom(84221));
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        apb(0, STATUS_OFS, 0, 32'h0, 0);
        apb(1, ACC_A_LOW_OFS, 32'hFFFFFFFF, 0, 0);
        apb(0, ACC_A_LOW_OFS, 0, 32'h0, 0);
        apb(0, 8'h24, 0, 32'h0, 1);
        apb(1, TRAP_CONTROL_OFS, 32'h7, 0, 0);
        foreach (rows[i])
        begin
            row = rows[i];
            apb(1, STATUS_OFS, 32'hC, 0, 0);
            apb(1, CORE_CONTROL_OFS, {24'h0, row.cc}, 0, 0);
            op(OP_ACCUM, row.s, 3'b010, row.v, WB_NONE, 0, 0, 0);
            op(OP_ACCUM, row.s, row.f, row.w, WB_NONE, 0, 0, 0);
            @(negedge clock_i);
            chk("trap", trap_request_o, |row.st[1:0] | (row.st[2] & ~row.cc[7])
                | (row.st[3] & ~row.cc[6]));
            apb(0, STATUS_OFS, 0, {24'h0, row.st}, 0);
            apb(0, row.s ? ACC_B_LOW_OFS : ACC_A_LOW_OFS, 0, row.r[31:0], 0);
            apb(0, row.s ? ACC_B_HIGH_OFS : ACC_A_HIGH_OFS, 0, {24'h0, row.r[39:32]}, 0);
        end
        apb(1, TRAP_CONTROL_OFS, 32'h0, 0, 0);
        @(negedge clock_i);
        chk("trap_masked", trap_request_o, 1'b0);
        apb(1, CORE_CONTROL_OFS, 32'h0, 0, 0);
        op(OP_ACCUM, 0, 3'b010, 40'h7FFFFFFFFF, WB_NONE, 0, 0, 0);
        op(OP_ACCUM, 0, 3'b000, 40'h1, WB_NONE, 0, 0, 0);
        op(OP_ACCUM, 0, 3'b010, 40'h0, WB_NONE, 0, 0, 0);
        apb(0, STATUS_OFS, 0, 32'h3E, 0);
        apb(1, STATUS_OFS, 32'h4, 0, 0);
        apb(0, STATUS_OFS, 0, 32'h3A, 0);
        foreach (rnds[i])
        begin
            rnd = rnds[i];
            if (i == 4)
                rnd.v[14:0] = 15'($urandom);
            apb(1, CORE_CONTROL_OFS, {24'h0, rnd.cc}, 0, 0);
            op(OP_ACCUM, 1, 3'b010, rnd.v, WB_NONE, 0, 0, 0);
            op(OP_STORE, 1, 3'b000, 0, WB_NONE, rnd.r, rnd.d, 0);
            apb(0, ACC_B_LOW_OFS, 0, rnd.v[31:0], 0);
        end
        apb(1, WB_POINTER_OFS, 32'h0100, 0, 0);
        exp_q.push_back(32'h01009000);
        exp_q.push_back(32'h01029000);
        op(OP_ACCUM, 0, 3'b010, 0, WB_INDIRECT, 0, 0, 1);
        op(OP_ACCUM, 0, 3'b010, 0, WB_INDIRECT, 0, 0, 0);
        op(OP_ACCUM_NO_WB, 0, 3'b010, 0, WB_INDIRECT, 0, 0, 0);
        apb(0, WB_POINTER_OFS, 0, 32'h0104, 0);
        op(OP_ACCUM, 0, 3'b010, 0, WB_DIRECT, 0, 0, 0);
        apb(0, WB_POINTER_OFS, 0, 32'h9000, 0);
        repeat (2) @(posedge clock_i);
        chk("pending", exp_q.size(), 0);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
